// ==== core/adc_boundary_scan_check.sv ====
// scan-chain and register control of the converter front end
`timescale 1ns/10ps
module adc_boundary_scan_check (
   input wire logic aclk, // system clock, 50 MHz
   input wire logic aresetn, // sync reset, active low
   input wire logic awvalid, // write address valid
   output logic awready, // write address ready
   input wire logic [afe_scan_pkg::ADDR_W-1:0] awaddr, // write address
   input wire logic wvalid, // write data valid
   output logic wready, // write data ready
   input wire logic [31:0] wdata, // write data
   input wire logic [3:0] wstrb, // write byte strobes
   output logic bvalid, // write response valid
   input wire logic bready, // write response ready
   output logic [1:0] bresp, // write response
   input wire logic arvalid, // read address valid
   output logic arready, // read address ready
   input wire logic [afe_scan_pkg::ADDR_W-1:0] araddr, // read address
   output logic rvalid, // read data valid
   input wire logic rready, // read data ready
   output logic [31:0] rdata, // read data
   output logic [1:0] rresp, // read response
   input wire logic tck, // test clock pin
   input wire logic tdi, // scan data in pin
   input wire logic scan_shift, // high: shift on test clock rise
   input wire logic scan_update, // high: update on test clock rise
   output logic tdo, // scan data out pin
   input wire logic [afe_scan_pkg::VAL_W-1:0] sample_level, // analog level
   output logic probe_to_ch4, // x10 stage routed to channel 4 pin
   output logic supply_ref_on, // supply used as reference
   output logic [afe_scan_pkg::NEG_W-1:0] minus_select // negative input
);
   import afe_scan_pkg::*;

   // ------------------------------------------------------------
   // pin synchronisers
   // ------------------------------------------------------------
   logic [3:0] pin_m_ff, pin_s_ff;
   logic tck_d_ff;
   logic [VAL_W-1:0] lvl_m_ff, lvl_s_ff;
   logic tck_rise, tck_fall, tdi_s, shift_s, update_s;

   // level is assumed quasi-static while it is sampled
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pin_m_ff <= 4'h0;
         pin_s_ff <= 4'h0;
         tck_d_ff <= 1'b0;
         lvl_m_ff <= '0;
         lvl_s_ff <= '0;
      end else begin
         pin_m_ff <= {scan_update, scan_shift, tdi, tck};
         pin_s_ff <= pin_m_ff;
         tck_d_ff <= pin_s_ff[0];
         lvl_m_ff <= sample_level;
         lvl_s_ff <= lvl_m_ff;
      end
   end

   assign tck_rise = pin_s_ff[0] && !tck_d_ff;
   assign tck_fall = !pin_s_ff[0] && tck_d_ff;
   assign tdi_s = pin_s_ff[1];
   assign shift_s = pin_s_ff[2];
   assign update_s = pin_s_ff[3];

   // ------------------------------------------------------------
   // scan cells
   // ------------------------------------------------------------
   afe_if fe_bus ();
   logic [SCAN_LEN-1:0] chain_ff, nxt_chain;
   ctl_t upd_ff, nxt_upd;
   ctl_t act_ff, nxt_act;
   logic tdo_ff, nxt_tdo;
   logic scan_mode_ff;
   ctl_t ctl_ff;

   always_comb begin
      nxt_chain = chain_ff;
      nxt_upd = upd_ff;
      nxt_tdo = tdo_ff;
      if (tck_rise) begin
         if (update_s)
            nxt_upd = ctl_t'(chain_ff[CTL_W-1:0]);
         else if (shift_s)
            nxt_chain = {tdi_s, chain_ff[SCAN_LEN-1:1]};
         else
            // result of the previous step leaves on this shift
            nxt_chain = {fe_bus.comp, act_ff};
      end
      if (tck_fall)
         nxt_tdo = chain_ff[0];
      nxt_act = scan_mode_ff ? upd_ff : ctl_ff;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         chain_ff <= '0;
         upd_ff <= CTL_IDLE;
         act_ff <= CTL_IDLE;
         tdo_ff <= 1'b0;
      end else begin
         chain_ff <= nxt_chain;
         upd_ff <= nxt_upd;
         act_ff <= nxt_act;
         tdo_ff <= nxt_tdo;
      end
   end

   // ------------------------------------------------------------
   // analog-facing outputs
   // ------------------------------------------------------------
   logic probe_ff, vref_ff;
   logic [NEG_W-1:0] neg_ff;

   // one negative source at a time is left to the controller
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         probe_ff <= 1'b0;
         vref_ff <= 1'b0;
         neg_ff <= NEG_IDLE;
      end else begin
         probe_ff <= act_ff.switchcap_probe_on;
         vref_ff <= act_ff.supply_reference_select;
         neg_ff <= act_ff.minus_input_select;
      end
   end

   assign fe_bus.ctl = act_ff;
   assign fe_bus.level = lvl_s_ff;
   assign fe_bus.normal = !scan_mode_ff;

   afe_front_end u_fe (
      .aclk (aclk),
      .aresetn (aresetn),
      .fe (fe_bus.fe_side)
   );

   // ------------------------------------------------------------
   // register slave
   // ------------------------------------------------------------
   logic aw_hold_ff, nxt_aw_hold, w_hold_ff, nxt_w_hold;
   logic [5:0] waddr_ff, nxt_waddr;
   logic [31:0] wdata_ff, nxt_wdata;
   logic [3:0] wstrb_ff, nxt_wstrb;
   logic bvalid_ff, nxt_bvalid, rvalid_ff, nxt_rvalid;
   logic [1:0] bresp_ff, nxt_bresp, rresp_ff, nxt_rresp;
   logic [31:0] rdata_ff, nxt_rdata;
   logic awready_ff, wready_ff, arready_ff;
   logic nxt_awready, nxt_wready, nxt_arready;
   logic scan_nxt;
   ctl_t ctl_nxt;
   logic [31:0] wmask, ctrl_word, cur_word, new_word;

   function automatic logic [31:0] pack_ctrl(ctl_t c, logic s);
      logic [31:0] w;
      w = '0;
      w[CTL_CHAN +: CHAN_W] = c.channel_select;
      w[CTL_NEG +: NEG_W] = c.minus_input_select;
      w[CTL_HOLD] = c.sample_hold;
      w[CTL_LRN] = c.comparator_latch_reset_n;
      w[CTL_PWR] = c.converter_power_on;
      w[CTL_VREF] = c.supply_reference_select;
      w[CTL_PROBE] = c.switchcap_probe_on;
      w[CTL_PASS] = c.gain_pass_gate_on;
      w[CTL_SPD] = c.gain_speedup;
      w[CTL_AMP] = c.gain_stage_power;
      w[CTL_SCAN] = s;
      return w;
   endfunction

   always_comb begin
      wmask = {{8{wstrb_ff[3]}}, {8{wstrb_ff[2]}},
         {8{wstrb_ff[1]}}, {8{wstrb_ff[0]}}};
      ctrl_word = pack_ctrl(ctl_ff, scan_mode_ff);
      cur_word = waddr_ff == IDX_VALUE ?
         {22'h0, ctl_ff.comparison_value} : ctrl_word;
      new_word = (cur_word & ~wmask) | (wdata_ff & wmask);
      nxt_aw_hold = aw_hold_ff;
      nxt_w_hold = w_hold_ff;
      nxt_waddr = waddr_ff;
      nxt_wdata = wdata_ff;
      nxt_wstrb = wstrb_ff;
      nxt_bvalid = bvalid_ff && !bready;
      nxt_bresp = bresp_ff;
      ctl_nxt = ctl_ff;
      scan_nxt = scan_mode_ff;
      if (awvalid && awready_ff) begin
         nxt_aw_hold = 1'b1;
         nxt_waddr = awaddr[7:2];
      end
      if (wvalid && wready_ff) begin
         nxt_w_hold = 1'b1;
         nxt_wdata = wdata;
         nxt_wstrb = wstrb;
      end
      if (aw_hold_ff && w_hold_ff && !bvalid_ff) begin
         nxt_aw_hold = 1'b0;
         nxt_w_hold = 1'b0;
         nxt_bvalid = 1'b1;
         nxt_bresp = RESP_OK;
         case (waddr_ff)
            IDX_CTRL: begin
               ctl_nxt.channel_select = new_word[CTL_CHAN +: CHAN_W];
               ctl_nxt.minus_input_select = new_word[CTL_NEG +: NEG_W];
               ctl_nxt.sample_hold = new_word[CTL_HOLD];
               ctl_nxt.comparator_latch_reset_n = new_word[CTL_LRN];
               ctl_nxt.converter_power_on = new_word[CTL_PWR];
               ctl_nxt.supply_reference_select = new_word[CTL_VREF];
               ctl_nxt.switchcap_probe_on = new_word[CTL_PROBE];
               ctl_nxt.gain_pass_gate_on = new_word[CTL_PASS];
               ctl_nxt.gain_speedup = new_word[CTL_SPD];
               ctl_nxt.gain_stage_power = new_word[CTL_AMP];
               scan_nxt = new_word[CTL_SCAN];
            end
            IDX_VALUE: ctl_nxt.comparison_value = new_word[VAL_W-1:0];
            default: nxt_bresp = RESP_ERR;
         endcase
      end
      nxt_awready = !nxt_aw_hold;
      nxt_wready = !nxt_w_hold;
      nxt_rvalid = rvalid_ff && !rready;
      nxt_rdata = rdata_ff;
      nxt_rresp = rresp_ff;
      if (arvalid && arready_ff) begin
         nxt_rvalid = 1'b1;
         nxt_rresp = RESP_OK;
         case (araddr[7:2])
            IDX_CTRL: nxt_rdata = ctrl_word;
            IDX_VALUE: nxt_rdata = {22'h0, ctl_ff.comparison_value};
            IDX_STAT: begin
               nxt_rdata = 32'h0;
               nxt_rdata[STAT_COMP] = fe_bus.comp;
               nxt_rdata[STAT_BUSY] = fe_bus.busy;
               nxt_rdata[STAT_READY] = fe_bus.ready;
               nxt_rdata[STAT_SCAN] = scan_mode_ff;
            end
            default: begin
               nxt_rdata = 32'h0;
               nxt_rresp = RESP_ERR;
            end
         endcase
      end
      nxt_arready = !nxt_rvalid;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_hold_ff <= 1'b0;
         w_hold_ff <= 1'b0;
         waddr_ff <= 6'h0;
         wdata_ff <= 32'h0;
         wstrb_ff <= 4'h0;
         bvalid_ff <= 1'b0;
         bresp_ff <= RESP_OK;
         rvalid_ff <= 1'b0;
         rresp_ff <= RESP_OK;
         rdata_ff <= 32'h0;
         awready_ff <= 1'b0;
         wready_ff <= 1'b0;
         arready_ff <= 1'b0;
         ctl_ff <= CTL_IDLE;
         scan_mode_ff <= 1'b0;
      end else begin
         aw_hold_ff <= nxt_aw_hold;
         w_hold_ff <= nxt_w_hold;
         waddr_ff <= nxt_waddr;
         wdata_ff <= nxt_wdata;
         wstrb_ff <= nxt_wstrb;
         bvalid_ff <= nxt_bvalid;
         bresp_ff <= nxt_bresp;
         rvalid_ff <= nxt_rvalid;
         rresp_ff <= nxt_rresp;
         rdata_ff <= nxt_rdata;
         awready_ff <= nxt_awready;
         wready_ff <= nxt_wready;
         arready_ff <= nxt_arready;
         ctl_ff <= ctl_nxt;
         scan_mode_ff <= scan_nxt;
      end
   end

   assign awready = awready_ff;
   assign wready = wready_ff;
   assign bvalid = bvalid_ff;
   assign bresp = bresp_ff;
   assign arready = arready_ff;
   assign rvalid = rvalid_ff;
   assign rdata = rdata_ff;
   assign rresp = rresp_ff;
   assign tdo = tdo_ff;
   assign probe_to_ch4 = probe_ff;
   assign supply_ref_on = vref_ff;
   assign minus_select = neg_ff;

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   update_load_a: assert property (@(posedge aclk)
      disable iff (!aresetn)
      tck_rise && update_s |=> upd_ff == ctl_t'($past(chain_ff[CTL_W-1:0])))
      else $error("update cells not loaded from chain");
   capture_comp_a: assert property (@(posedge aclk)
      disable iff (!aresetn)
      tck_rise && !update_s && !shift_s |=>
      chain_ff[SCAN_LEN-1] == $past(fe_bus.comp))
      else $error("comparator result not captured");
   tdo_out_a: assert property (@(posedge aclk) disable iff (!aresetn)
      tck_fall |=> tdo == $past(chain_ff[0]))
      else $error("scan out not driven on falling edge");
   probe_route_a: assert property (@(posedge aclk)
      disable iff (!aresetn)
      scan_mode_ff && upd_ff.switchcap_probe_on ##1
      scan_mode_ff && upd_ff.switchcap_probe_on |=> probe_to_ch4)
      else $error("probe route not following enable");
   supply_ref_a: assert property (@(posedge aclk)
      disable iff (!aresetn)
      !scan_mode_ff && ctl_ff.supply_reference_select [*3] |->
      supply_ref_on)
      else $error("supply reference not selected");
   minus_sel_a: assert property (@(posedge aclk)
      disable iff (!aresetn)
      $stable(act_ff) |=> minus_select == $past(act_ff.minus_input_select))
      else $error("minus select does not follow controls");
   write_resp_a: assert property (@(posedge aclk) disable iff (!aresetn)
      aw_hold_ff && w_hold_ff && !bvalid_ff |=> bvalid ##0
      (bresp == RESP_ERR) == ($past(waddr_ff) > IDX_VALUE))
      else $error("write response missing or wrong");
endmodule

// ==== core/afe_scan_pkg.sv ====
// constants and types for the scan-controlled converter front end
//
// Functional notes
// - latch low precharges with result, high holds
// - probe enable routes x10 stage to pin
// - reference select high uses supply voltage
// - three minus-select bits pick negative input
// - power-on runs 10-comparison dummy (normal mode only; skipped in scan mode), 200ns wait
// - sample while hold low, hold while high
// - 10-bit comparison value, bit 9 MSB
package afe_scan_pkg;
   // -----------------------------------------------------------
   // register map
   // -----------------------------------------------------------
   localparam int ADDR_W = 8;
   localparam logic [5:0] IDX_CTRL = 6'h00;
   localparam logic [5:0] IDX_VALUE = 6'h01;
   localparam logic [5:0] IDX_STAT = 6'h02;
   localparam int CTL_CHAN = 0;
   localparam int CTL_NEG = 8;
   localparam int CTL_HOLD = 11;
   localparam int CTL_LRN = 12;
   localparam int CTL_PWR = 13;
   localparam int CTL_VREF = 14;
   localparam int CTL_PROBE = 15;
   localparam int CTL_PASS = 16;
   localparam int CTL_SPD = 17;
   localparam int CTL_AMP = 18;
   localparam int CTL_SCAN = 31;
   localparam int STAT_COMP = 0;
   localparam int STAT_BUSY = 1;
   localparam int STAT_READY = 2;
   localparam int STAT_SCAN = 3;
   localparam logic [1:0] RESP_OK = 2'h0;
   localparam logic [1:0] RESP_ERR = 2'h2;
   // -----------------------------------------------------------
   // front-end controls, packed in scan order (bit 0 first)
   // -----------------------------------------------------------
   localparam int VAL_W = 10;
   localparam int CHAN_W = 8;
   localparam int NEG_W = 3;
   typedef struct packed {
      logic converter_power_on;
      logic gain_stage_power;
      logic [VAL_W-1:0] comparison_value;
      logic sample_hold;
      logic [CHAN_W-1:0] channel_select;
      logic [NEG_W-1:0] minus_input_select;
      logic gain_pass_gate_on;
      logic comparator_latch_reset_n;
      logic switchcap_probe_on;
      logic gain_speedup;
      logic supply_reference_select;
   } ctl_t;
   localparam int CTL_W = $bits(ctl_t);
   localparam int SCAN_LEN = CTL_W + 1;
   localparam logic [VAL_W-1:0] VALUE_MID = 10'h200;
   localparam logic [CHAN_W-1:0] CHAN_IDLE = 8'h01;
   localparam logic [NEG_W-1:0] NEG_IDLE = 3'h0;
   localparam ctl_t CTL_IDLE = '{1'b0, 1'b0, VALUE_MID, 1'b1, CHAN_IDLE,
      NEG_IDLE, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0};
   // -----------------------------------------------------------
   // timing
   // -----------------------------------------------------------
   localparam int CLK_NS = 20;
   localparam int SETTLE_NS = 200;
   localparam int SETTLE_CYC = (SETTLE_NS + CLK_NS - 1) / CLK_NS;
   localparam int DUMMY_CMP = 10;
endpackage

// ==== core/afe_if.sv ====
// link between the scan/register logic and the converter front end
`timescale 1ns/10ps
interface afe_if;
   import afe_scan_pkg::*;
   ctl_t ctl;
   logic [VAL_W-1:0] level;
   logic normal;
   logic comp;
   logic busy;
   logic ready;
   modport ctl_side (output ctl, level, normal, input comp, busy, ready);
   modport fe_side (input ctl, level, normal, output comp, busy, ready);
endinterface

// ==== core/afe_front_end.sv ====
// converter front end: sample/hold, comparator latch, power-up dummy
`timescale 1ns/10ps
module afe_front_end (
   input wire logic aclk, // system clock
   input wire logic aresetn, // sync reset, active low
   afe_if.fe_side fe // controls in, result out
);
   import afe_scan_pkg::*;
   typedef enum logic [1:0] {off_s, dummy_s, on_s} pwr_t;
   pwr_t pwr_ff, nxt_pwr;
   logic [VAL_W-1:0] held_ff, nxt_held;
   logic comp_ff, nxt_comp;
   logic [4:0] busy_run_ff, nxt_busy_run;
   logic [4:0] cnt_ff, nxt_cnt;
   logic [4:0] settle_ff, nxt_settle;

   always_comb begin
      nxt_held = held_ff;
      nxt_comp = comp_ff;
      nxt_pwr = pwr_ff;
      nxt_cnt = cnt_ff;
      nxt_settle = settle_ff;
      if (!fe.ctl.sample_hold)
         nxt_held = fe.level;
      // latch loads while low so the limit result is readable
      // in the next step; high keeps it through the restore
      if (!fe.ctl.comparator_latch_reset_n)
         // high when the value lies above the held input
         nxt_comp = fe.ctl.comparison_value > held_ff;
      nxt_busy_run = fe.busy ? busy_run_ff + 5'd1 : 5'd0;
      case (pwr_ff)
         off_s: begin
            nxt_settle = 5'd0;
            if (fe.ctl.converter_power_on) begin
               nxt_cnt = 5'd0;
               nxt_pwr = fe.normal ? dummy_s : on_s;
            end
         end
         dummy_s: begin
            nxt_cnt = cnt_ff + 5'd1;
            if (cnt_ff == 5'(DUMMY_CMP - 1))
               nxt_pwr = on_s;
         end
         on_s: ;
         default: nxt_pwr = off_s;
      endcase
      if (pwr_ff != off_s && settle_ff != 5'(SETTLE_CYC))
         nxt_settle = settle_ff + 5'd1;
      if (!fe.ctl.converter_power_on)
         nxt_pwr = off_s;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         held_ff <= VALUE_MID;
         comp_ff <= 1'b0;
         busy_run_ff <= 5'd0;
         pwr_ff <= off_s;
         cnt_ff <= 5'd0;
         settle_ff <= 5'd0;
      end else begin
         held_ff <= nxt_held;
         comp_ff <= nxt_comp;
         busy_run_ff <= nxt_busy_run;
         pwr_ff <= nxt_pwr;
         cnt_ff <= nxt_cnt;
         settle_ff <= nxt_settle;
      end
   end

   assign fe.comp = comp_ff;
   assign fe.busy = pwr_ff == dummy_s;
   assign fe.ready = pwr_ff == on_s && settle_ff == 5'(SETTLE_CYC);

   sample_track_a: assert property (@(posedge aclk) disable iff (!aresetn)
      !fe.ctl.sample_hold |=> held_ff == $past(fe.level))
      else $error("held level does not track while sampling");
   hold_keep_a: assert property (@(posedge aclk) disable iff (!aresetn)
      fe.ctl.sample_hold |=> $stable(held_ff))
      else $error("held level moved while holding");
   latch_precharge_a: assert property (@(posedge aclk)
      disable iff (!aresetn)
      !fe.ctl.comparator_latch_reset_n |=>
      comp_ff == $past(fe.ctl.comparison_value > held_ff))
      else $error("comparator latch not loaded while low");
   latch_eval_a: assert property (@(posedge aclk) disable iff (!aresetn)
      fe.ctl.comparator_latch_reset_n |=> comp_ff == $past(comp_ff))
      else $error("comparator result not held while high");
   dummy_len_a: assert property (@(posedge aclk) disable iff (!aresetn)
      $fell(fe.busy) && pwr_ff == on_s |-> busy_run_ff == 5'(DUMMY_CMP))
      else $error("dummy conversion length wrong");
   ready_wait_a: assert property (@(posedge aclk) disable iff (!aresetn)
      $rose(fe.ready) |-> $past(fe.ctl.converter_power_on, 10))
      else $error("ready before settling time");
endmodule

// ==== dv/scan_ctl_model.sv ====
// boundary-scan test controller model driving the converter scan chain
`timescale 1ns/10ps
module scan_ctl_model (
   output logic tck, // test clock, still between steps
   output logic tdi, // scan data into chain
   output logic scan_shift, // shift select
   output logic scan_update, // update select
   input wire logic tdo // scan data out of chain
);
   import afe_scan_pkg::*;
   initial begin
      tck = 1'h0;
      tdi = 1'h0;
      scan_shift = 1'h0;
      scan_update = 1'h0;
   end
   // -----------------------------------------------------------
   // one step: capture, shift whole chain, update
   // -----------------------------------------------------------
   // 160 ns period keeps four held steps short of any hold limit
   task automatic step(input ctl_t pat, output logic [SCAN_LEN-1:0] got);
      logic [SCAN_LEN-1:0] sh;
      sh = {1'h0, pat};
      #87 tck = 1'h1;
      #80 tck = 1'h0;
      scan_shift = 1'h1;
      for (int i = 0; i < SCAN_LEN; i++) begin
         tdi = sh[i];
         #80 tck = 1'h1;
         // tdo moves only after a fall, so mid-high is safe to sample
         #40 got[i] = tdo;
         #40 tck = 1'h0;
      end
      scan_shift = 1'h0;
      scan_update = 1'h1;
      #80 tck = 1'h1;
      #80 tck = 1'h0;
      scan_update = 1'h0;
      // released data line must not keep its last value
      tdi = ~tdi;
   endtask
endmodule

// ==== dv/tb_adc_boundary_scan_check.sv ====
// self-checking bench: register bus and scan-chain range check
`timescale 1ns/10ps
module tb_adc_boundary_scan_check;
   import afe_scan_pkg::*;
   localparam logic [7:0] A_CTRL = {IDX_CTRL, 2'h0};
   localparam logic [7:0] A_VAL = {IDX_VALUE, 2'h0};
   localparam logic [7:0] A_STAT = {IDX_STAT, 2'h0};
   logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
   logic awready, wready, bvalid, arready, rvalid, tdo;
   logic tck, tdi, scan_shift, scan_update, probe_to_ch4, supply_ref_on;
   logic [ADDR_W-1:0] awaddr, araddr;
   logic [31:0] wdata, rdata, rd, idle_w;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp, rs;
   logic [VAL_W-1:0] sample_level;
   logic [NEG_W-1:0] minus_select;
   logic [SCAN_LEN-1:0] got;
   ctl_t pat, prev;
   int fail_count, total_checks;
   adc_boundary_scan_check dut (.aclk, .aresetn, .awvalid, .awready,
      .awaddr, .wvalid, .wready, .wdata, .wstrb, .bvalid, .bready, .bresp,
      .arvalid, .arready, .araddr, .rvalid, .rready, .rdata, .rresp, .tck,
      .tdi, .scan_shift, .scan_update, .tdo, .sample_level, .probe_to_ch4,
      .supply_ref_on, .minus_select);
   scan_ctl_model scan (.tck, .tdi, .scan_shift, .scan_update, .tdo);
   initial begin
      aclk = 1'h0;
      forever #10 aclk = ~aclk;
   end
   // -----------------------------------------------------------
   // compare, bus and closing tasks
   // -----------------------------------------------------------
   task automatic chk_word(input logic [31:0] g, input logic [31:0] e);
      total_checks++;
      if (g !== e) begin
         fail_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic chk_resp(input logic [1:0] g, input logic [1:0] e);
      total_checks++;
      if (g !== e) begin
         fail_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic wchk(input logic [7:0] a, input logic [31:0] d,
         input logic [3:0] s, input logic [1:0] er);
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      wstrb <= s;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
      do begin
         @(posedge aclk);
         if (awready) awvalid <= 1'h0;
         if (wready) wvalid <= 1'h0;
      end while (bvalid !== 1'h1);
      bready <= 1'h0;
      chk_resp(bresp, er);
   endtask
   task automatic rchk(input logic [7:0] a, input logic [31:0] e,
         input logic [1:0] er, input logic [31:0] m);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'h1;
      rready <= 1'h1;
      do begin
         @(posedge aclk);
         if (arready) arvalid <= 1'h0;
      end while (rvalid !== 1'h1);
      rd = rdata;
      rs = rresp;
      rready <= 1'h0;
      chk_word(rd & m, e);
      chk_resp(rs, er);
   endtask
   task automatic chk_pins(input logic [31:0] e);
      repeat (3) @(posedge aclk);
      #1;
      chk_word(32'({probe_to_ch4, supply_ref_on, minus_select}), e);
   endtask
   task automatic conclude;
      $display("checks=%0d failures=%0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   // whole run needs about 60 us; far beyond that means a hang
   initial begin
      #300000;
      fail_count++;
      conclude;
   end
   // -----------------------------------------------------------
   // test sequence
   // -----------------------------------------------------------
   initial begin
      aresetn = 1'h0;
      {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
      awaddr = 8'h0;
      araddr = 8'h0;
      wdata = 32'h0;
      wstrb = 4'h0;
      sample_level = 10'h133;
      idle_w = (32'h1 << CTL_HOLD) | (32'h1 << CTL_LRN) | 32'(CHAN_IDLE);
      idle_w = idle_w | (32'h1 << CTL_PASS);
      repeat (16) @(posedge aclk);
      aresetn <= 1'h1;
      repeat (4) @(posedge aclk);
      #1;
      chk_word(32'({awready, wready, arready, bvalid, rvalid}), 32'h1c);
      chk_pins(32'h0);
      rchk(A_CTRL, idle_w, RESP_OK, 32'hffffffff);
      rchk(A_VAL, 32'(VALUE_MID), RESP_OK, 32'hffffffff);
      rchk(8'h0c, 32'h0, RESP_ERR, 32'hffffffff);
      wchk(A_STAT, 32'hffffffff, 4'hf, RESP_ERR);
      rchk(A_STAT, 32'h0, RESP_OK, 32'h0a);
      wchk(A_VAL, 32'hffffff01, 4'h2, RESP_OK);
      rchk(A_VAL, 32'h300, RESP_OK, 32'hffffffff);
      wchk(A_CTRL, idle_w | 32'hc500, 4'hf, RESP_OK);
      chk_pins(32'h1d);
      wchk(A_CTRL, idle_w | (32'h1 << CTL_PWR), 4'hf, RESP_OK);
      rchk(A_STAT, 32'h2, RESP_OK, 32'h6);
      chk_pins(32'h0);
      repeat (DUMMY_CMP + 2) @(posedge aclk);
      rchk(A_STAT, 32'h4, RESP_OK, 32'h6);
      wchk(A_CTRL, idle_w | 32'h80000000, 4'hf, RESP_OK);
      rchk(A_STAT, 32'h8, RESP_OK, 32'h8);
      prev = CTL_IDLE;
      for (int k = 1; k <= 11; k++) begin
         pat = CTL_IDLE;
         pat.converter_power_on = 1'h1;
         pat.channel_select = 8'h08;
         pat.sample_hold = (k != 2 && k != 7);
         pat.comparator_latch_reset_n = (k != 5 && k != 10);
         pat.comparison_value = (k == 4 || k == 5) ? 10'h123 :
            (k == 9 || k == 10) ? 10'h143 : VALUE_MID;
         scan.step(pat, got);
         chk_word(32'(got[CTL_W-1:0]), 32'(prev));
         if (k == 6 || k == 11)
            chk_word(32'(got[CTL_W]), (k == 11) ? 32'h1 : 32'h0);
         prev = pat;
      end
      chk_pins(32'h0);
      conclude;
   end
endmodule
